// ===== pkg/eeprom_map.vh
// Behaviour
// - 512-byte array, program and erase supported
// - reset copies nonvolatile bytes into volatile registers
// - nonvolatile bytes use the array sequence
// - 35 us timebase from selected reference clock
// - armed protect freezes secured 16 bytes
// - armed protect refuses config byte changes
// - armed protect refuses block and bulk erase
// - four 128-byte blocks, one protect bit each
// - protect bits reload on reset or read
// - divider lock blocks divider changes after reset
// - erased bits read one, delivered as FF
// - program result is old AND data
// - erase sets bits, byte up to array
// - enable needs latch and valid latched address
// - latch captures valid writes, last wins
// - auto mode timer clears enable itself
// - clearing enable and latch together keeps latch
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

`define CTRL_OFS      16'h0000
`define ACR_OFS       16'h0004
`define DIVH_OFS      16'h0008
`define DIVL_OFS      16'h000C
`define CLKSEL_OFS    16'h0010
`define STATUS_OFS    16'h0014
`define CFG_NV_OFS    16'h0018
`define DIVH_NV_OFS   16'h001C
`define DIVL_NV_OFS   16'h0020
`define ARRAY_IDX_LO  16'h0800
`define ARRAY_IDX_HI  16'h09FF
`define ARRAY_BASE    16'h2000
`define ARRAY_LAST    16'h27FC

`define TGT_CFG       10'h200
`define TGT_DIVH      10'h201
`define TGT_DIVL      10'h202

`define CTL_PE        0
`define CTL_LAT       1
`define CTL_MODE_LO   2
`define CTL_MODE_HI   3
`define CTL_AUTO      4
`define CTL_SPARE     7
`define PERM_BIT      4
`define DIV_LOCK_BIT  7

`define MODE_PGM      2'h0
`define MODE_BYTE_ER  2'h1
`define MODE_BLK_ER   2'h2
`define MODE_BULK_ER  2'h3

`define ERASED_BYTE   8'hFF
`define CLKSEL_RST    1'b0
`define TIMEBASE_US   35
`define PGM_TICKS     16'h0008
`define BYTE_TICKS    16'h0008
`define BLK_TICKS     16'h0010
`define BULK_TICKS    16'h0020

`endif

// ===== hdl/ee_timebase.v
`timescale 1ns/10ps
`include "eeprom_map.vh"

module ee_timebase #(
  parameter DIV_W = 16
) (
  input  wire             clock_in,
  input  wire             reset_n_in,
  input  wire             crystal_ref_clock_in,
  input  wire             clk_sel_in,
  input  wire [DIV_W-1:0] divisor_in,
  output reg              tick_out
);

  reg             sync1_reg;
  reg             sync2_reg;
  reg             sync3_reg;
  reg             level_reg;
  reg [DIV_W-1:0] count_reg;
  wire            xtal_rise;
  wire            step;
  wire [DIV_W-1:0] last;

  // a rise counts once second and third stages agree
  assign xtal_rise = sync2_reg & sync3_reg & ~level_reg;
  assign step      = clk_sel_in ? xtal_rise : 1'b1;
  assign last      = (divisor_in == {DIV_W{1'b0}}) ? {DIV_W{1'b0}}
                     : divisor_in - {{(DIV_W-1){1'b0}}, 1'b1};

  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
      count_reg <= {DIV_W{1'b0}};
      tick_out  <= 1'b0;
    end else begin
      sync1_reg <= crystal_ref_clock_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        level_reg <= sync3_reg;
      end
      tick_out <= 1'b0;
      if (step) begin
        // divide selected reference by divisor
        if (count_reg >= last) begin
          count_reg <= {DIV_W{1'b0}};
          tick_out  <= 1'b1;
        end else begin
          count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ee_timebase

// ===== hdl/eeprom_ctrl.v
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "eeprom_map.vh"

module eeprom_ctrl #(
  parameter        ARRAY_BYTES = 512,
  parameter [15:0] PGM_TICKS   = `PGM_TICKS,
  parameter [15:0] BYTE_TICKS  = `BYTE_TICKS,
  parameter [15:0] BLK_TICKS   = `BLK_TICKS,
  parameter [15:0] BULK_TICKS  = `BULK_TICKS
) (
  input  wire        clock_in,
  input  wire        reset_n_in,
  input  wire        hsel_in,
  input  wire [15:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  input  wire        crystal_ref_clock_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  output reg         pump_on_out,
  output reg         busy_out
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_TIMING = 2'h1;
  localparam [1:0] ST_SWEEP  = 2'h2;

  reg [7:0]  mem [0:ARRAY_BYTES-1];
  reg [7:0]  config_nv_byte_reg;
  reg [7:0]  divider_nv_high_reg;
  reg [7:0]  divider_nv_low_reg;
  reg [7:0]  array_config_reg;
  reg [7:0]  timebase_divider_high_reg;
  reg [7:0]  timebase_divider_low_reg;
  reg        divider_clock_select_reg;
  reg        program_erase_enable_reg;
  reg        bus_latch_enable_reg;
  reg [1:0]  mode_reg;
  reg        auto_reg;
  reg        spare_reg;
  reg [9:0]  lat_addr_reg;
  reg [7:0]  lat_data_reg;
  reg        lat_valid_reg;
  reg [1:0]  state_reg;
  reg [15:0] tick_cnt_reg;
  reg [8:0]  sweep_idx_reg;
  reg        refused_reg;
  reg        dp_wr_reg;
  reg [15:0] dp_addr_reg;
  reg [31:0] rd_data;
  reg        mem_we;
  reg [9:0]  mem_idx;
  reg [7:0]  mem_wdata;
  reg [7:0]  old_byte;
  reg [15:0] load_ticks;
  wire       tick;
  wire       ap_take;
  wire       ap_read;
  wire [10:0] rd_tgt;
  wire [10:0] wr_tgt;
  wire       wr_ctrl;
  wire       div_open;
  wire       need_sweep;
  wire       timing_done;
  wire       abort;
  wire       sweep_hit;
  integer    i;

  // decode bus address into array or nonvolatile target
  function [10:0] target_of;
    input [15:0] a;
    begin
      if (a >= `ARRAY_BASE && a <= `ARRAY_LAST && a[1:0] == 2'h0) begin
        target_of = {2'b10, a[10:2]};
      end else if (a == `CFG_NV_OFS) begin
        target_of = {1'b1, `TGT_CFG};
      end else if (a == `DIVH_NV_OFS) begin
        target_of = {1'b1, `TGT_DIVH};
      end else if (a == `DIVL_NV_OFS) begin
        target_of = {1'b1, `TGT_DIVL};
      end else begin
        target_of = 11'h000;
      end
    end
  endfunction

  // refusal of an operation on a target
  function blocked;
    input [9:0] code;
    input [1:0] mode;
    input [7:0] cfg;
    input [7:0] acr;
    input       open;
    reg         perm;
    begin
      perm = ~cfg[`PERM_BIT];
      if (code == `TGT_CFG) begin
        blocked = perm;
      end else if (code == `TGT_DIVH || code == `TGT_DIVL) begin
        blocked = ~open;
      end else if (mode[1]) begin
        blocked = perm | ((mode == `MODE_BLK_ER) & acr[code[8:7]]);
      end else begin
        blocked = acr[code[8:7]] | (perm & (code[8:4] == 5'h0F));
      end
    end
  endfunction

  ee_timebase #(
    .DIV_W (16)
  ) timebase (
    .clock_in             (clock_in),
    .reset_n_in           (reset_n_in),
    .crystal_ref_clock_in (crystal_ref_clock_in),
    .clk_sel_in           (divider_clock_select_reg),
    .divisor_in           ({1'b0, timebase_divider_high_reg[6:0],
                            timebase_divider_low_reg}),
    .tick_out             (tick)
  );

  assign ap_take     = hsel_in & hready_in & htrans_in[1];
  assign ap_read     = ap_take & ~hwrite_in;
  assign rd_tgt      = target_of(haddr_in);
  assign wr_tgt      = target_of(dp_addr_reg);
  assign wr_ctrl     = dp_wr_reg & (dp_addr_reg == `CTRL_OFS);
  assign div_open    = timebase_divider_high_reg[`DIV_LOCK_BIT];
  assign need_sweep  = ~lat_addr_reg[9] & mode_reg[1];
  assign abort       = wr_ctrl & ~hwdata_in[`CTL_PE];
  assign timing_done = (state_reg == ST_TIMING) & tick & (tick_cnt_reg <= 16'h0001);
  assign sweep_hit   = ~array_config_reg[sweep_idx_reg[8:7]] &
                       ((mode_reg == `MODE_BULK_ER) |
                        (sweep_idx_reg[8:7] == lat_addr_reg[8:7]));

  // bus address phase
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      dp_wr_reg     <= 1'b0;
      dp_addr_reg   <= 16'h0000;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      dp_wr_reg     <= ap_take & hwrite_in;
      dp_addr_reg   <= haddr_in;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (ap_read) begin
        hrdata_out <= rd_data;
      end
    end
  end

  // read mux
  always @* begin
    case (haddr_in)
      `CTRL_OFS: begin
        rd_data = {24'h00_0000, spare_reg, 2'b00, auto_reg, mode_reg,
                   bus_latch_enable_reg, program_erase_enable_reg};
      end
      `ACR_OFS:     rd_data = {24'h00_0000, array_config_reg};
      `DIVH_OFS:    rd_data = {24'h00_0000, timebase_divider_high_reg};
      `DIVL_OFS:    rd_data = {24'h00_0000, timebase_divider_low_reg};
      `CLKSEL_OFS:  rd_data = {31'h0000_0000, divider_clock_select_reg};
      `STATUS_OFS: begin
        rd_data = {29'h0000_0000, lat_valid_reg, refused_reg, busy_out};
      end
      `CFG_NV_OFS:  rd_data = {24'h00_0000, config_nv_byte_reg};
      `DIVH_NV_OFS: rd_data = {24'h00_0000, divider_nv_high_reg};
      `DIVL_NV_OFS: rd_data = {24'h00_0000, divider_nv_low_reg};
      default: begin
        if (rd_tgt[10] & ~rd_tgt[9]) begin
          rd_data = {24'h00_0000, mem[rd_tgt[8:0]]};
        end else begin
          rd_data = 32'h0000_0000;
        end
      end
    endcase
  end

  // volatile copies of the nonvolatile settings, and the reference clock select
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      array_config_reg          <= config_nv_byte_reg;
      timebase_divider_high_reg <= divider_nv_high_reg;
      timebase_divider_low_reg  <= divider_nv_low_reg;
      divider_clock_select_reg  <= `CLKSEL_RST;
    end else begin
      if (ap_read && haddr_in == `CFG_NV_OFS) begin
        array_config_reg <= config_nv_byte_reg;
      end
      if (dp_wr_reg && dp_addr_reg == `DIVH_OFS && div_open) begin
        timebase_divider_high_reg <= hwdata_in[7:0];
      end
      if (dp_wr_reg && dp_addr_reg == `DIVL_OFS && div_open) begin
        timebase_divider_low_reg <= hwdata_in[7:0];
      end
      if (dp_wr_reg && dp_addr_reg == `CLKSEL_OFS) begin
        divider_clock_select_reg <= hwdata_in[0];
      end
    end
  end

  // operation length per mode
  always @* begin
    case (mode_reg)
      `MODE_PGM:     load_ticks = PGM_TICKS;
      `MODE_BYTE_ER: load_ticks = BYTE_TICKS;
      `MODE_BLK_ER:  load_ticks = BLK_TICKS;
      default:       load_ticks = BULK_TICKS;
    endcase
  end

  // control bits, latch and operation sequencer
  always @(posedge clock_in) begin
    if (!reset_n_in) begin
      program_erase_enable_reg <= 1'b0;
      bus_latch_enable_reg     <= 1'b0;
      mode_reg                 <= `MODE_PGM;
      auto_reg                 <= 1'b0;
      spare_reg                <= 1'b0;
      lat_addr_reg             <= 10'h000;
      lat_data_reg             <= 8'h00;
      lat_valid_reg            <= 1'b0;
      state_reg                <= ST_IDLE;
      tick_cnt_reg             <= 16'h0000;
      sweep_idx_reg            <= 9'h000;
      refused_reg              <= 1'b0;
      pump_on_out              <= 1'b0;
      busy_out                 <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sweep_idx_reg <= 9'h000;
        end
        ST_TIMING: begin
          if (tick) begin
            tick_cnt_reg <= tick_cnt_reg - 16'h0001;
          end
          if (timing_done) begin
            if (need_sweep && !refused_reg) begin
              state_reg <= ST_SWEEP;
            end else begin
              state_reg <= ST_IDLE;
              if (auto_reg) begin
                program_erase_enable_reg <= 1'b0;
              end
            end
          end
        end
        ST_SWEEP: begin
          sweep_idx_reg <= sweep_idx_reg + 9'h001;
          if (sweep_idx_reg == 9'h1FF) begin
            state_reg <= ST_IDLE;
            if (auto_reg) begin
              program_erase_enable_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase

      // capture valid array or nonvolatile byte writes while latching
      if (dp_wr_reg && wr_tgt[10] && bus_latch_enable_reg &&
          !program_erase_enable_reg) begin
        lat_addr_reg  <= wr_tgt[9:0];
        lat_data_reg  <= hwdata_in[7:0];
        lat_valid_reg <= 1'b1;
      end

      if (wr_ctrl) begin
        spare_reg <= hwdata_in[`CTL_SPARE];
        if (!program_erase_enable_reg) begin
          mode_reg <= hwdata_in[`CTL_MODE_HI:`CTL_MODE_LO];
          auto_reg <= hwdata_in[`CTL_AUTO];
        end
        // latch cannot drop while enable is set
        bus_latch_enable_reg <= program_erase_enable_reg |
                                hwdata_in[`CTL_LAT];
        if (!program_erase_enable_reg && !hwdata_in[`CTL_LAT]) begin
          lat_valid_reg <= 1'b0;
        end
        if (hwdata_in[`CTL_PE] && hwdata_in[`CTL_LAT] &&
            !program_erase_enable_reg && bus_latch_enable_reg &&
            lat_valid_reg) begin
          program_erase_enable_reg <= 1'b1;
          state_reg                <= ST_TIMING;
          tick_cnt_reg             <= load_ticks;
          refused_reg              <= blocked(lat_addr_reg,
                                              hwdata_in[`CTL_MODE_HI:`CTL_MODE_LO],
                                              config_nv_byte_reg, array_config_reg,
                                              div_open);
        end else if (abort && program_erase_enable_reg) begin
          program_erase_enable_reg <= 1'b0;
          state_reg                <= ST_IDLE;
        end
      end

      pump_on_out <= program_erase_enable_reg & ~refused_reg &
                     (state_reg != ST_IDLE) & ~abort;
      busy_out    <= (state_reg != ST_IDLE);
    end
  end

  // current content of the latched target
  always @* begin
    case (lat_addr_reg)
      `TGT_CFG:  old_byte = config_nv_byte_reg;
      `TGT_DIVH: old_byte = divider_nv_high_reg;
      `TGT_DIVL: old_byte = divider_nv_low_reg;
      default:   old_byte = mem[lat_addr_reg[8:0]];
    endcase
  end

  // array update request
  always @* begin
    mem_we    = 1'b0;
    mem_idx   = lat_addr_reg;
    mem_wdata = `ERASED_BYTE;
    if (timing_done && !refused_reg && !need_sweep && !abort) begin
      mem_we = 1'b1;
      if (mode_reg == `MODE_PGM) begin
        mem_wdata = old_byte & lat_data_reg;
      end else begin
        mem_wdata = `ERASED_BYTE;
      end
    end else if (state_reg == ST_SWEEP && sweep_hit && !abort) begin
      mem_we    = 1'b1;
      mem_idx   = {1'b0, sweep_idx_reg};
      mem_wdata = `ERASED_BYTE;
    end
  end

  // delivered erased
  initial begin
    for (i = 0; i < ARRAY_BYTES; i = i + 1) begin
      mem[i] = `ERASED_BYTE;
    end
    config_nv_byte_reg  = `ERASED_BYTE;
    divider_nv_high_reg = `ERASED_BYTE;
    divider_nv_low_reg  = `ERASED_BYTE;
  end

  // nonvolatile storage, untouched by reset
  always @(posedge clock_in) begin
    if (mem_we) begin
      case (mem_idx)
        `TGT_CFG:  config_nv_byte_reg  <= mem_wdata;
        `TGT_DIVH: divider_nv_high_reg <= mem_wdata;
        `TGT_DIVL: divider_nv_low_reg  <= mem_wdata;
        default:   mem[mem_idx[8:0]]   <= mem_wdata;
      endcase
    end
  end

endmodule // eeprom_ctrl

// ===== verification/eeprom_ctrl_properties.sv
`timescale 1ns/10ps
`include "eeprom_map.vh"
module eeprom_ctrl_properties (
  input wire        clock_in,
  input wire        reset_n_in,
  input wire        hsel_in,
  input wire [15:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        pump_on_out,
  input wire        busy_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  wire        rd_taken;
  logic [12:0] busy_run;
  assign rd_taken = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  // length of the current busy stretch
  always @(posedge clock_in) begin
    if (!reset_n_in || !busy_out)
      busy_run <= 13'h0000;
    else
      busy_run <= busy_run + 13'h0001;
  end
  ready_always_a: assert property (hreadyout_out == 1'b1)
    else $error("hreadyout low");
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("hresp not okay");
  reset_clear_a: assert property ($rose(reset_n_in) |->
    !busy_out && !pump_on_out && hrdata_out == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  upper_zero_a: assert property (hrdata_out[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  rdata_hold_a: assert property (!$past(rd_taken) |-> $stable(hrdata_out))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd_taken && haddr_in == 16'h0024
    |=> hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  status_busy_a: assert property (rd_taken && haddr_in == `STATUS_OFS
    |=> hrdata_out[0] == $past(busy_out))
    else $error("status busy mismatch");
  busy_bound_a: assert property (busy_run < 13'h0FA0)
    else $error("busy never ends");
  pump_busy_a: assert property (pump_on_out |-> busy_out)
    else $error("pump on outside an operation");
  cover property ($rose(busy_out));
  cover property ($rose(pump_on_out));
  cover property (rd_taken && haddr_in == `STATUS_OFS);
endmodule // eeprom_ctrl_properties

bind eeprom_ctrl eeprom_ctrl_properties i_props (
  .clock_in(clock_in),
  .reset_n_in(reset_n_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hready_in(hready_in),
  .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .pump_on_out(pump_on_out),
  .busy_out(busy_out)
);

// ===== verification/cpu_bus_master.sv
`timescale 1ns/10ps
module cpu_bus_master (
  input  wire         clock_in,
  input  wire         reset_n_in,
  input  wire         go_in,
  input  wire         write_in,
  input  wire [15:0]  addr_in,
  input  wire [31:0]  wdata_in,
  input  wire         hready_in,
  input  wire [31:0]  hrdata_in,
  output logic        hsel_out = 1'b0,
  output logic [1:0]  htrans_out = 2'h0,
  output logic [15:0] haddr_out = 16'h0000,
  output logic        hwrite_out = 1'b0,
  output logic [31:0] hwdata_out = 32'h0000_0000,
  output logic        done_out = 1'b0,
  output logic [31:0] rdata_out = 32'h0000_0000
);
  logic [1:0] phase_reg = 2'h0;
  // single transfers, idle lines toggle
  always @(posedge clock_in) begin
    done_out <= 1'b0;
    if (!reset_n_in) begin
      phase_reg  <= 2'h0;
      hsel_out   <= 1'b0;
      htrans_out <= 2'h0;
    end else if (phase_reg == 2'h0) begin
      if (go_in) begin
        hsel_out   <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out  <= addr_in;
        hwrite_out <= write_in;
        phase_reg  <= 2'h1;
      end else begin
        haddr_out  <= ~haddr_out;
        hwdata_out <= ~hwdata_out;
      end
    end else if (hready_in) begin
      if (phase_reg == 2'h1) begin
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= wdata_in;
        phase_reg  <= 2'h2;
      end else begin
        rdata_out <= hrdata_in;
        done_out  <= 1'b1;
        phase_reg <= 2'h0;
      end
    end
  end
endmodule // cpu_bus_master

// ===== verification/eeprom_program_erase_control_bench.sv
`timescale 1ns/10ps
`include "eeprom_map.vh"
module eeprom_program_erase_control_bench;
  localparam int pgm_t = 4;
  localparam logic [49:0] row_tab [17] = '{
    {2'h0, 16'h2000, 8'hFE, 16'h2000, 8'hFE},
    {2'h0, 16'h2000, 8'hFD, 16'h2000, 8'hFC},
    {2'h1, 16'h2000, 8'h00, 16'h2000, 8'hFF},
    {2'h0, 16'h27FC, 8'h00, 16'h27FC, 8'hFF},
    {2'h0, 16'h25FC, 8'h00, 16'h25FC, 8'h00},
    {2'h2, 16'h2400, 8'h00, 16'h25FC, 8'hFF},
    {2'h0, 16'h23C0, 8'h3C, 16'h23C0, 8'h3C},
    {2'h3, 16'h2000, 8'h00, 16'h23C0, 8'hFF},
    {2'h0, 16'h23C0, 8'h3C, 16'h23C0, 8'h3C},
    {2'h0, 16'h0018, 8'hEF, 16'h0018, 8'hE8},
    {2'h1, 16'h23C0, 8'h00, 16'h23C0, 8'h3C},
    {2'h1, 16'h0018, 8'h00, 16'h0018, 8'hE8},
    {2'h0, 16'h2040, 8'h55, 16'h2040, 8'h55},
    {2'h2, 16'h2040, 8'h00, 16'h2040, 8'h55},
    {2'h3, 16'h2040, 8'h00, 16'h2040, 8'h55},
    {2'h0, 16'h0020, 8'h01, 16'h0020, 8'h01},
    {2'h0, 16'h001C, 8'h00, 16'h001C, 8'h00}};
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        crystal = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] r;
  wire         hsel;
  wire [1:0]   htrans;
  wire [15:0]  haddr;
  wire         hwrite;
  wire [31:0]  hwdata;
  wire         done;
  wire [31:0]  rdata;
  wire [31:0]  hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         pump_on;
  wire         busy;
  int          miscompares = 0;
  int          tests_run = 0;
  int          busy_cycles;
  int          pump_seen;
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  initial begin
    #7;
    forever #50 crystal = ~crystal;
  end
  cpu_bus_master i_cpu (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .go_in(go),
    .write_in(wr),
    .addr_in(adr),
    .wdata_in(wd),
    .hready_in(hreadyout),
    .hrdata_in(hrdata),
    .hsel_out(hsel),
    .htrans_out(htrans),
    .haddr_out(haddr),
    .hwrite_out(hwrite),
    .hwdata_out(hwdata),
    .done_out(done),
    .rdata_out(rdata)
  );
  eeprom_ctrl #(
    .PGM_TICKS(16'h0004),
    .BYTE_TICKS(16'h0002),
    .BLK_TICKS(16'h0002),
    .BULK_TICKS(16'h0002)
  ) i_dut (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .hsel_in(hsel),
    .haddr_in(haddr),
    .htrans_in(htrans),
    .hwrite_in(hwrite),
    .hsize_in(3'h2),
    .hwdata_in(hwdata),
    .hready_in(hreadyout),
    .crystal_ref_clock_in(crystal),
    .hrdata_out(hrdata),
    .hreadyout_out(hreadyout),
    .hresp_out(hresp),
    .pump_on_out(pump_on),
    .busy_out(busy)
  );
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    miscompares++;
    $display("ERROR t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    go <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clock_in);
    go <= 1'b0;
    while (done !== 1'b1 && n < 50) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 50) begin
      bad(n, 50);
      final_report;
    end
    r = rdata;
  endtask
  task automatic chk(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    tests_run++;
    if (r !== e)
      bad(r, e);
  endtask
  task automatic wait_busy;
    int n;
    n = 0;
    busy_cycles = 0;
    pump_seen = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    if (busy !== 1'b1) begin
      bad(n, 20);
      final_report;
    end
    while (busy === 1'b1 && busy_cycles < 5000) begin
      if (pump_on === 1'b1)
        pump_seen++;
      @(posedge clock_in);
      busy_cycles++;
    end
    if (busy_cycles >= 5000) begin
      bad(busy_cycles, 0);
      final_report;
    end
  endtask
  // latch, target write, enable with auto, then release
  task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, `CTRL_OFS, {27'h000_0000, 1'b1, m, 2'h2});
    bus(1'b1, a, {24'h00_0000, d});
    bus(1'b1, `CTRL_OFS, {27'h000_0000, 1'b1, m, 2'h3});
    wait_busy;
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    chk(`ACR_OFS, 32'h0000_00FF);
    chk(`DIVL_OFS, 32'h0000_00FF);
    chk(16'h0024, 32'h0000_0000);
    bus(1'b1, `DIVH_OFS, 32'h0000_0080);
    bus(1'b1, `DIVL_OFS, 32'h0000_0001);
    chk(`DIVH_OFS, 32'h0000_0080);
    bus(1'b1, `CTRL_OFS, 32'h0000_0081);
    chk(`CTRL_OFS, 32'h0000_0080);
    bus(1'b1, `CTRL_OFS, 32'h0000_0002);
    bus(1'b1, `CTRL_OFS, 32'h0000_0003);
    chk(`CTRL_OFS, 32'h0000_0002);
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
    op(2'h0, 16'h2000, 8'h00);
    chk(16'h2000, 32'h0000_00FF);
    bus(1'b0, `STATUS_OFS, 32'h0000_0000);
    tests_run++;
    if (r[1] !== 1'b1)
      bad(r, 32'h0000_0002);
    tests_run++;
    if (pump_seen != 0)
      bad(pump_seen, 0);
    op(2'h0, `CFG_NV_OFS, 8'hF8);
    tests_run++;
    if (pump_seen == 0)
      bad(pump_seen, 1);
    chk(`ACR_OFS, 32'h0000_00FF);
    chk(`CFG_NV_OFS, 32'h0000_00F8);
    chk(`ACR_OFS, 32'h0000_00F8);
    for (int i = 0; i < 17; i++) begin
      op(row_tab[i][49:48], row_tab[i][47:32], row_tab[i][31:24]);
      chk(row_tab[i][23:8], {24'h00_0000, row_tab[i][7:0]});
    end
    bus(1'b1, `CTRL_OFS, 32'h0000_0012);
    bus(1'b1, 16'h2000, 32'h0000_000F);
    bus(1'b1, 16'h2004, 32'h0000_00A5);
    bus(1'b1, `CTRL_OFS, 32'h0000_0013);
    wait_busy;
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
    chk(16'h2000, 32'h0000_00FF);
    chk(16'h2004, 32'h0000_00A5);
    bus(1'b1, `CTRL_OFS, 32'h0000_0002);
    bus(1'b1, 16'h2008, 32'h0000_0033);
    bus(1'b1, `CTRL_OFS, 32'h0000_0003);
    wait_busy;
    chk(`CTRL_OFS, 32'h0000_0003);
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
    chk(`CTRL_OFS, 32'h0000_0002);
    bus(1'b1, `CTRL_OFS, 32'h0000_0000);
    chk(16'h2008, 32'h0000_0033);
    bus(1'b1, `DIVL_OFS, 32'h0000_0004);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, `CLKSEL_OFS, k);
      op(2'h0, 16'h200C + 16'h0004 * k, 8'hF0);
      tests_run++;
      if (busy_cycles < pgm_t * 3 * (3 * k + 1) || busy_cycles > pgm_t * 6 * (3 * k + 1))
        bad(busy_cycles, pgm_t * 4 * (3 * k + 1));
    end
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    chk(`ACR_OFS, 32'h0000_00E8);
    chk(`DIVH_OFS, 32'h0000_0000);
    bus(1'b1, `DIVH_OFS, 32'h0000_0080);
    bus(1'b1, `DIVL_OFS, 32'h0000_0007);
    chk(`DIVH_OFS, 32'h0000_0000);
    chk(`DIVL_OFS, 32'h0000_0001);
    op(2'h0, `DIVL_NV_OFS, 8'hFE);
    chk(`DIVL_NV_OFS, 32'h0000_0001);
    final_report;
  end
endmodule // eeprom_program_erase_control_bench
